// ==== ocrp_pkg.sv ====
// package: constants and carriers for the offboard command/response post block
package ocrp_pkg;

  // ****************************************************************
  // register map (word index; byte address = index * 4 not used here)
  // ****************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_RSP_PTR = 4'h1;
  localparam logic [3:0] REG_ONB_RSP_ADDR = 4'h2;
  localparam logic [3:0] REG_ERR_LVL_VEC = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_MASK = 4'h6;
  localparam logic [3:0] REG_RSP_STATUS = 4'h7;
  localparam logic [3:0] REG_SLOT_CTRL = 4'h8;
  localparam logic [3:0] REG_SLOT_ADDR = 4'h9;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SLOT_FETCH_BIT = 4;
  localparam int SLOT_OWN_BIT = 15;
  localparam int RSP_VALID_BIT = 15;
  localparam int INIT_WORD_ONB_RSP = 6;
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FETCH_ERR = 1;
  localparam int IRQ_POST_ERR = 2;
  localparam int IRQ_TGT_ERR = 3;

  // ****************************************************************
  // reset values and error codes
  // ****************************************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_FETCH_BERR = 8'h01;
  localparam logic [7:0] ERR_POST_BERR = 8'h02;
  localparam logic [7:0] ERR_TARGET = 8'h03;

  typedef enum logic [2:0] {
    OCRP_IDLE = 3'b000,
    OCRP_FETCH = 3'b001,
    OCRP_EXEC = 3'b010,
    OCRP_POST = 3'b011,
    OCRP_ONB = 3'b100,
    OCRP_IRQ = 3'b101
  } ocrp_state_t;

  // dma request toward the bus mover
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [15:0] len;
  } ocrp_dma_req_t;

  // dma answer from the bus mover
  typedef struct packed {
    logic done;
    logic berr;
  } ocrp_dma_rsp_t;

endpackage

// ==== ocrp_irq.sv ====
// interrupt status, mask and level output
`timescale 1ns/1ps

module ocrp_irq #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] event_set,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [W-1:0] stat;
    logic [W-1:0] mask;
  } ocrp_irq_st_t;

  ocrp_irq_st_t s_q;
  ocrp_irq_st_t s_d;

  always_comb begin
    s_d = s_q;
    // set wins over a write-one clear in the same cycle
    if (clr_we) begin
      s_d.stat = s_q.stat & ~wdata;
    end
    s_d.stat = s_d.stat | event_set;
    if (mask_we) begin
      s_d.mask = wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.stat;
  assign mask = s_q.mask;
  assign irq = |(s_q.stat & s_q.mask);

endmodule

// ==== ocrp_top.sv ====
// command fetch and response posting engine with register port
`timescale 1ns/1ps

module ocrp_top #(
  parameter logic [15:0] ENTRY_LEN = 16'h0018
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // dma mover
  output ocrp_pkg::ocrp_dma_req_t dma_req,
  input wire ocrp_pkg::ocrp_dma_rsp_t dma_rsp,
  // command execution engine
  output logic exec_start,
  input wire logic exec_done,
  input wire logic exec_target_err,
  // onboard response copy strobe and error level/vector for the host irq
  output logic onb_copy,
  output logic [31:0] onb_copy_addr,
  output logic [7:0] irq_level_vector,
  output logic irq
);

  initial begin
    if (ENTRY_LEN == 16'h0000) begin
      $error("ENTRY_LEN must be non-zero");
    end
  end

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rs1_q;
  logic rs2_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ocrp_pkg::ocrp_state_t st;
    logic [15:0] slot_ctrl;
    logic [31:0] slot_addr;
    logic [31:0] rsp_ptr;
    logic [31:0] rsp_ptr_act;
    logic [31:0] onb_rsp_addr;
    logic [7:0] err_lv;
    logic [15:0] rsp_status;
    logic [7:0] err_code;
    logic dma_busy;
    logic [31:0] rdata;
    ocrp_pkg::ocrp_dma_req_t dma;
    logic exec_go;
    logic copy;
    logic [31:0] copy_addr;
    logic [7:0] lv_out;
    logic init_pend;
  } ocrp_st_t;

  ocrp_st_t s_q;
  ocrp_st_t s_d;

  logic [ocrp_pkg::IRQ_W-1:0] ev;
  logic [ocrp_pkg::IRQ_W-1:0] irq_stat;
  logic [ocrp_pkg::IRQ_W-1:0] irq_mask;
  logic clr_we;
  logic mask_we;

  assign clr_we = reg_we && reg_addr == ocrp_pkg::REG_IRQ_STAT;
  assign mask_we = reg_we && reg_addr == ocrp_pkg::REG_IRQ_MASK;

  ocrp_irq #(
    .W(ocrp_pkg::IRQ_W)
  ) u_irq (
    .core_clk(core_clk),
    .rst_n(rs2_q),
    .event_set(ev),
    .clr_we(clr_we),
    .mask_we(mask_we),
    .wdata(reg_wdata[ocrp_pkg::IRQ_W-1:0]),
    .status(irq_stat),
    .mask(irq_mask),
    .irq(irq)
  );

  logic rsp_valid;
  assign rsp_valid = s_q.rsp_status[ocrp_pkg::RSP_VALID_BIT];

  always_comb begin
    s_d = s_q;
    ev = '0;
    s_d.exec_go = 1'b0;
    s_d.copy = 1'b0;
    s_d.dma.req = 1'b0;
    s_d.rdata = 32'h0000_0000;

    // ****************************************************************
    // register writes
    // ****************************************************************
    if (reg_we) begin
      unique case (reg_addr)
        ocrp_pkg::REG_CTRL: begin
          // controller init latches the pointer in force
          if (reg_wdata[0]) begin
            s_d.init_pend = 1'b1;
          end
        end
        ocrp_pkg::REG_RSP_PTR: s_d.rsp_ptr = reg_wdata;
        ocrp_pkg::REG_ONB_RSP_ADDR: s_d.onb_rsp_addr = reg_wdata;
        ocrp_pkg::REG_ERR_LVL_VEC: s_d.err_lv = reg_wdata[7:0];
        ocrp_pkg::REG_RSP_STATUS: begin
          // host clears valid; error status goes with it
          if (!reg_wdata[ocrp_pkg::RSP_VALID_BIT]) begin
            s_d.rsp_status = 16'h0000;
            s_d.err_code = ocrp_pkg::ERR_NONE;
          end
        end
        ocrp_pkg::REG_SLOT_CTRL: s_d.slot_ctrl = reg_wdata[15:0];
        ocrp_pkg::REG_SLOT_ADDR: s_d.slot_addr = reg_wdata;
        default: ;
      endcase
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    if (reg_re) begin
      unique case (reg_addr)
        ocrp_pkg::REG_CTRL: s_d.rdata = {31'h0, s_q.init_pend};
        ocrp_pkg::REG_RSP_PTR: s_d.rdata = s_q.rsp_ptr;
        ocrp_pkg::REG_ONB_RSP_ADDR: s_d.rdata = s_q.onb_rsp_addr;
        ocrp_pkg::REG_ERR_LVL_VEC: s_d.rdata = {24'h0, s_q.err_lv};
        ocrp_pkg::REG_STATUS: s_d.rdata = {29'h0, s_q.st};
        ocrp_pkg::REG_IRQ_STAT: s_d.rdata = {28'h0, irq_stat};
        ocrp_pkg::REG_IRQ_MASK: s_d.rdata = {28'h0, irq_mask};
        ocrp_pkg::REG_RSP_STATUS: begin
          s_d.rdata = {8'h0, s_q.err_code, s_q.rsp_status};
        end
        ocrp_pkg::REG_SLOT_CTRL: s_d.rdata = {16'h0, s_q.slot_ctrl};
        ocrp_pkg::REG_SLOT_ADDR: s_d.rdata = s_q.slot_addr;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // ****************************************************************
    // command sequencer
    // ****************************************************************
    unique case (s_q.st)
      ocrp_pkg::OCRP_IDLE: begin
        if (s_q.init_pend) begin
          s_d.rsp_ptr_act = s_q.rsp_ptr;
          s_d.init_pend = 1'b0;
        end else if (s_q.slot_ctrl[ocrp_pkg::SLOT_OWN_BIT] && !rsp_valid) begin
          // wait for the host to free the response block first
          if (s_q.slot_ctrl[ocrp_pkg::SLOT_FETCH_BIT]) begin
            s_d.dma.req = 1'b1;
            s_d.dma.wr = 1'b0;
            s_d.dma.addr = s_q.slot_addr;
            s_d.dma.len = ENTRY_LEN;
            s_d.st = ocrp_pkg::OCRP_FETCH;
          end else begin
            s_d.slot_ctrl[ocrp_pkg::SLOT_OWN_BIT] = 1'b0;
            s_d.exec_go = 1'b1;
            s_d.st = ocrp_pkg::OCRP_EXEC;
          end
        end
      end
      ocrp_pkg::OCRP_FETCH: begin
        if (dma_rsp.done || dma_rsp.berr) begin
          s_d.slot_ctrl[ocrp_pkg::SLOT_OWN_BIT] = 1'b0;
        end
        if (dma_rsp.berr) begin
          // failed fetch: raw entry goes onboard under default level
          s_d.err_code = ocrp_pkg::ERR_FETCH_BERR;
          s_d.lv_out = s_q.err_lv;
          s_d.copy = 1'b1;
          s_d.copy_addr = s_q.onb_rsp_addr;
          ev[ocrp_pkg::IRQ_FETCH_ERR] = 1'b1;
          s_d.st = ocrp_pkg::OCRP_ONB;
        end else if (dma_rsp.done) begin
          s_d.exec_go = 1'b1;
          s_d.st = ocrp_pkg::OCRP_EXEC;
        end
      end
      ocrp_pkg::OCRP_EXEC: begin
        if (exec_done) begin
          s_d.lv_out = 8'h00;
          if (exec_target_err) begin
            s_d.err_code = ocrp_pkg::ERR_TARGET;
            ev[ocrp_pkg::IRQ_TGT_ERR] = 1'b1;
          end
          if (s_q.rsp_ptr_act != 32'h0000_0000) begin
            // target errors post remotely too
            s_d.dma.req = 1'b1;
            s_d.dma.wr = 1'b1;
            s_d.dma.addr = s_q.rsp_ptr_act;
            s_d.dma.len = ENTRY_LEN;
            s_d.st = ocrp_pkg::OCRP_POST;
          end else begin
            s_d.copy = 1'b1;
            s_d.copy_addr = s_q.onb_rsp_addr;
            s_d.st = ocrp_pkg::OCRP_ONB;
          end
        end
      end
      ocrp_pkg::OCRP_POST: begin
        if (dma_rsp.berr) begin
          s_d.err_code = ocrp_pkg::ERR_POST_BERR;
          s_d.copy = 1'b1;
          s_d.copy_addr = s_q.onb_rsp_addr;
          ev[ocrp_pkg::IRQ_POST_ERR] = 1'b1;
          s_d.st = ocrp_pkg::OCRP_ONB;
        end else if (dma_rsp.done) begin
          s_d.st = ocrp_pkg::OCRP_IRQ;
        end
      end
      ocrp_pkg::OCRP_ONB: begin
        s_d.st = ocrp_pkg::OCRP_IRQ;
      end
      ocrp_pkg::OCRP_IRQ: begin
        // done interrupt only after data has landed; error bits are set earlier, on the error or exec_done cycle
        s_d.rsp_status[ocrp_pkg::RSP_VALID_BIT] = 1'b1;
        ev[ocrp_pkg::IRQ_DONE] = 1'b1;
        s_d.st = ocrp_pkg::OCRP_IDLE;
      end
      default: s_d.st = ocrp_pkg::OCRP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rs2_q) begin
    if (!rs2_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign dma_req = s_q.dma;
  assign exec_start = s_q.exec_go;
  assign onb_copy = s_q.copy;
  assign onb_copy_addr = s_q.copy_addr;
  assign irq_level_vector = s_q.lv_out;

endmodule

// ==== ocrp_chk_assertions.sv ====
// checker for the command fetch and response post engine
`timescale 1ns/1ps
module ocrp_chk #(
  parameter logic [15:0] ENTRY_LEN = 16'h0018
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire ocrp_pkg::ocrp_dma_req_t dma_req,
  input wire ocrp_pkg::ocrp_dma_rsp_t dma_rsp,
  input wire logic exec_start,
  input wire logic exec_done,
  input wire logic exec_target_err,
  input wire logic onb_copy,
  input wire logic [31:0] onb_copy_addr,
  input wire logic [7:0] irq_level_vector,
  input wire logic irq
);
  logic rd_pend_q;
  logic wr_pend_q;
  logic [7:0] lvl_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      lvl_q <= 8'h00;
    end else begin
      if (dma_req.req) begin
        rd_pend_q <= !dma_req.wr;
        wr_pend_q <= dma_req.wr;
      end else if (dma_rsp.done || dma_rsp.berr) begin
        rd_pend_q <= 1'b0;
        wr_pend_q <= 1'b0;
      end
      if (reg_we && reg_addr == ocrp_pkg::REG_ERR_LVL_VEC) begin
        lvl_q <= reg_wdata[7:0];
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  dma_pulse_a: assert property (dma_req.req |=> !dma_req.req)
    else $error("dma request longer than one cycle");
  remote_addr_a: assert property (
    dma_req.req && dma_req.wr |-> dma_req.addr != 32'h0)
    else $error("response write to address zero");
  irq_after_dma_a: assert property ($rose(irq) |-> !wr_pend_q)
    else $error("interrupt before response write ended");
  fetch_berr_a: assert property (rd_pend_q && dma_rsp.berr |->
    ##[1:4] (onb_copy && irq_level_vector == lvl_q))
    else $error("fetch bus error not posted onboard");
  no_exec_berr_a: assert property (
    rd_pend_q && dma_rsp.berr |=> !exec_start [*4])
    else $error("command run after fetch bus error");
  fetch_ok_a: assert property (
    rd_pend_q && dma_rsp.done |-> ##[1:4] exec_start)
    else $error("fetched command not started");
  post_berr_a: assert property (
    wr_pend_q && dma_rsp.berr |-> ##[1:4] onb_copy)
    else $error("post bus error not copied onboard");
  rdata_hide_a: assert property (
    !$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  post_follow_a: assert property (exec_done |->
    ##[1:20] ((dma_req.req && dma_req.wr) || onb_copy))
    else $error("no response after completion");
  cover property (wr_pend_q && dma_rsp.berr);
  cover property (rd_pend_q && dma_rsp.berr);
  cover property ($rose(irq));
endmodule
bind ocrp_top ocrp_chk #(.ENTRY_LEN(ENTRY_LEN)) i_ocrp_chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_rsp(dma_rsp),
  .exec_start(exec_start), .exec_done(exec_done),
  .exec_target_err(exec_target_err), .onb_copy(onb_copy),
  .onb_copy_addr(onb_copy_addr), .irq_level_vector(irq_level_vector),
  .irq(irq));

// ==== ocrp_mover.sv ====
// host memory mover model answering dma requests
`timescale 1ns/1ps
module ocrp_mover (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ocrp_pkg::ocrp_dma_req_t dma_req,
  input wire logic rd_berr,
  input wire logic wr_berr,
  input wire logic slow,
  output ocrp_pkg::ocrp_dma_rsp_t dma_rsp
);
  logic busy_q;
  logic wr_q;
  int cnt_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 0;
      dma_rsp <= '0;
    end else begin
      dma_rsp <= '0;
      if (dma_req.req) begin
        busy_q <= 1'b1;
        wr_q <= dma_req.wr;
        cnt_q <= slow ? 9 : 1;
      end else if (busy_q && cnt_q == 0) begin
        busy_q <= 1'b0;
        // missing memory answers with a bus error
        if (wr_q ? wr_berr : rd_berr) begin
          dma_rsp.berr <= 1'b1;
        end else begin
          dma_rsp.done <= 1'b1;
        end
      end else if (busy_q) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule

// ==== offboard_command_response_post_tb.sv ====
// testbench for the command fetch and response post engine
`timescale 1ns/1ps
module offboard_command_response_post_tb;
  localparam logic [31:0] PTR = 32'h0001_0000;
  localparam logic [31:0] ONB = 32'h0000_0200;
  localparam logic [31:0] SADR = 32'h0000_8000;
  localparam logic [7:0] LVL = 8'h5a;
  logic core_clk, rst_n, reg_we, reg_re, exec_start, exec_done;
  logic exec_target_err, onb_copy, irq, rd_berr, wr_berr, slow, masked;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, onb_copy_addr;
  logic [7:0] irq_level_vector;
  ocrp_pkg::ocrp_dma_req_t dma_req;
  ocrp_pkg::ocrp_dma_rsp_t dma_rsp;
  int bad_count, checks_done, n_exec;
  ocrp_top i_ocrp_top (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .dma_req(dma_req),
    .dma_rsp(dma_rsp), .exec_start(exec_start), .exec_done(exec_done),
    .exec_target_err(exec_target_err), .onb_copy(onb_copy),
    .onb_copy_addr(onb_copy_addr), .irq_level_vector(irq_level_vector),
    .irq(irq));
  ocrp_mover i_ocrp_mover (.core_clk(core_clk), .rst_n(rst_n),
    .dma_req(dma_req), .rd_berr(rd_berr), .wr_berr(wr_berr),
    .slow(slow), .dma_rsp(dma_rsp));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (exec_start === 1'b1) n_exec++;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // 0 dma request, 1 exec start, 2 onboard copy, 3 irq
  task automatic waitfor(input int w);
    for (int i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if ((w == 0 && dma_req.req === 1'b1) || (w == 1 && exec_start === 1'b1)
        || (w == 2 && onb_copy === 1'b1) || (w == 3 && irq === 1'b1)) return;
    end
    chk(1'b0, "wait ran out");
  endtask
  task automatic exec_ack(input logic tgt);
    @(posedge core_clk);
    exec_done <= 1'b1;
    exec_target_err <= tgt;
    @(posedge core_clk);
    exec_done <= 1'b0;
    exec_target_err <= 1'b0;
  endtask
  task automatic clear();
    logic [31:0] d;
    wr(ocrp_pkg::REG_RSP_STATUS, 32'h0);
    rd(ocrp_pkg::REG_RSP_STATUS, d);
    chk(d[23:15] === 9'h000, "status kept");
    wr(ocrp_pkg::REG_IRQ_STAT, 32'hf);
    @(negedge core_clk);
    chk(irq === 1'b0, "irq stuck");
  endtask
  task automatic run_cmd(input bit fetch, rb, wbe, tgt, remote, hold,
    input logic [7:0] code);
    logic [31:0] d;
    int e0;
    rd(ocrp_pkg::REG_SLOT_CTRL, d);
    chk(d[15] === 1'b0, "slot busy");
    wr(ocrp_pkg::REG_SLOT_ADDR, SADR);
    wr(ocrp_pkg::REG_SLOT_CTRL, fetch ? 32'h8010 : 32'h8000);
    e0 = n_exec;
    if (fetch) begin
      waitfor(0);
      chk(dma_req.wr === 1'b0 && dma_req.addr === SADR, "fetch");
    end
    if (rb) waitfor(2);
    else begin
      waitfor(1);
      exec_ack(tgt);
      if (remote) begin
        waitfor(0);
        chk(dma_req.wr === 1'b1 && dma_req.addr === PTR && irq === 1'b0,
          "post");
      end
      if (!remote || wbe) begin
        waitfor(2);
        chk(onb_copy_addr === ONB, "onboard");
      end
    end
    if (masked) begin
      repeat (4) @(negedge core_clk);
      chk(irq === 1'b0, "masked irq");
    end else waitfor(3);
    if (rb) chk(irq_level_vector === LVL && onb_copy_addr === ONB, "lvl");
    chk(n_exec == e0 + (rb ? 0 : 1), "exec count");
    rd(ocrp_pkg::REG_SLOT_CTRL, d);
    chk(d[15] === 1'b0, "own kept");
    rd(ocrp_pkg::REG_RSP_STATUS, d);
    chk(d[15] === 1'b1 && d[23:16] === code, "status");
    if (!hold) clear();
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] d;
    logic [3:0] a [5] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'hf};
    foreach (a[i]) begin
      rd(a[i], d);
      chk(d === 32'h0, "reset value");
    end
  endtask
  task automatic t_onboard();
    logic [31:0] d;
    wr(ocrp_pkg::REG_ERR_LVL_VEC, {24'h0, LVL});
    wr(ocrp_pkg::REG_ONB_RSP_ADDR, ONB);
    run_cmd(0, 0, 0, 0, 0, 1, ocrp_pkg::ERR_NONE);
    rd(ocrp_pkg::REG_IRQ_STAT, d);
    chk(d[0] === 1'b1, "done bit");
    masked = 1'b0;
    wr(ocrp_pkg::REG_IRQ_MASK, 32'hf);
    @(negedge core_clk);
    chk(irq === 1'b1, "unmasked irq");
    clear();
  endtask
  task automatic t_remote();
    wr(ocrp_pkg::REG_RSP_PTR, PTR);
    wr(ocrp_pkg::REG_CTRL, 32'h1);
    run_cmd(1, 0, 0, 0, 1, 0, ocrp_pkg::ERR_NONE);
    // only the done bit drives irq: the target error bit rises in the same cycle as the post request
    wr(ocrp_pkg::REG_IRQ_MASK, 32'h1);
    run_cmd(0, 0, 0, 1, 1, 0, ocrp_pkg::ERR_TARGET);
  endtask
  task automatic t_berr();
    slow <= 1'b1;
    wr_berr <= 1'b1;
    run_cmd(1, 0, 1, 0, 1, 0, ocrp_pkg::ERR_POST_BERR);
    wr_berr <= 1'b0;
    rd_berr <= 1'b1;
    run_cmd(1, 1, 0, 0, 1, 0, ocrp_pkg::ERR_FETCH_BERR);
    rd_berr <= 1'b0;
    slow <= 1'b0;
  endtask
  task automatic t_guard();
    int e0;
    run_cmd(0, 0, 0, 0, 1, 1, ocrp_pkg::ERR_NONE);
    e0 = n_exec;
    wr(ocrp_pkg::REG_SLOT_CTRL, 32'h8000);
    repeat (20) @(negedge core_clk);
    chk(n_exec == e0, "ran while valid");
    // the held command starts one cycle after valid drops, so wait right away
    wr(ocrp_pkg::REG_IRQ_STAT, 32'hf);
    wr(ocrp_pkg::REG_RSP_STATUS, 32'h0);
    waitfor(1);
    exec_ack(1'b0);
    waitfor(0);
    waitfor(3);
    clear();
  endtask
  initial begin
    {rst_n, reg_we, reg_re, exec_done, exec_target_err} = '0;
    {rd_berr, wr_berr, slow, reg_addr, reg_wdata} = '0;
    masked = 1'b1;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_onboard();
    t_remote();
    t_berr();
    t_guard();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end
endmodule
